// >>> logic/fsc_params.svh
// constants for the fail-safe init configuration registers
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH

// ----------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------
`define FSC_SEL_FAULT_INPUT 1'b0
`define FSC_SEL_MACHINE 1'b1

// ----------------------------------------------------------------
// reset values and writable masks (bit 0 here is register bit 0)
// ----------------------------------------------------------------
`define FSC_FAULT_INPUT_RST 16'h41C6
`define FSC_FAULT_INPUT_MASK 16'hDDDE
`define FSC_MACHINE_RST 16'h5080
`define FSC_MACHINE_MASK 16'hDAB0

// ----------------------------------------------------------------
// field positions in the 16-bit word
// ----------------------------------------------------------------
`define FSC_POS_PAIRING 14
`define FSC_POS_PAIRED_POL 12
`define FSC_POS_IN_A_POL 11
`define FSC_POS_IN_B_POL 10
`define FSC_POS_PAIRED_REACT 8
`define FSC_POS_IN_A_REACT 7
`define FSC_POS_IN_B_REACT 6
`define FSC_POS_ERR_POL 4
`define FSC_POS_ERR_ACK 2
`define FSC_POS_ERR_REACT 1
`define FSC_POS_COUNT_LIMIT 14
`define FSC_POS_COUNT_REACT 11
`define FSC_POS_PULSE_SEL 9
`define FSC_POS_SHORT_HIGH 7
`define FSC_POS_CLOCK_OFF 5
`define FSC_POS_LONG_OFF 4
`define FSC_POS_FAULT_COUNT 0

// ----------------------------------------------------------------
// timing: times in microseconds, clock in MHz
// ----------------------------------------------------------------
`define FSC_CLK_MHZ 20
`define FSC_PULSE_LONG_US 10000
`define FSC_PULSE_SHORT_US 1000
`define FSC_LONG_LOW_US 8000000
`define FSC_PULSE_LONG_CYC (`FSC_PULSE_LONG_US * `FSC_CLK_MHZ)
`define FSC_PULSE_SHORT_CYC (`FSC_PULSE_SHORT_US * `FSC_CLK_MHZ)
`define FSC_LONG_LOW_CYC (`FSC_LONG_LOW_US * `FSC_CLK_MHZ)
`define FSC_FAULT_COUNT_MAX 4'hC

`endif

// >>> logic/fsc_pkg.sv
// types shared by the fail-safe init configuration block
package fsc_pkg;
  typedef logic [15:0] fsc_word_t;
  typedef logic [27:0] fsc_count_t;
endpackage

// >>> logic/fsc_timer.sv
// down-counting one-shot timer with load and clear
`timescale 1ns/1ps
module fsc_timer
  import fsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic start,
  input wire fsc_count_t load_val,
  input wire logic clear,
  // status
  output logic busy,
  output logic done
);
  fsc_count_t cnt_reg, cnt_next;
  logic done_reg, done_next;

  // clear wins over start so a disabled timer can never be armed
  always_comb begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (clear) begin
      cnt_next = '0;
    end else if (start) begin
      cnt_next = load_val;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 28'd1;
      done_next = (cnt_reg == 28'd1);
    end
  end

  // state registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign busy = (cnt_reg != '0);
  assign done = done_reg;
endmodule

// >>> logic/fsc_regs.sv
// fail-safe init configuration registers with reset pulse timer and 8 s long-low timer
`timescale 1ns/1ps
`include "fsc_params.svh"
module fsc_regs
  import fsc_pkg::*;
#(
  parameter int PULSE_LONG_CYC = `FSC_PULSE_LONG_CYC,
  parameter int PULSE_SHORT_CYC = `FSC_PULSE_SHORT_CYC,
  parameter int LONG_LOW_CYC = `FSC_LONG_LOW_CYC
)
(
  // clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // register port from the serial control logic
  input wire logic REG_SEL,
  input wire logic REG_WR,
  input wire fsc_word_t REG_WDATA,
  input wire logic REG_RD,
  output fsc_word_t REG_RDATA,
  // fail-safe state machine side (same clock)
  input wire logic RESET_REQ,
  input wire logic [3:0] FAULT_ERROR_COUNT,
  // pins and analog detectors (asynchronous)
  input wire logic FAILSAFE_SHORT_HIGH,
  input wire logic RESET_PIN_LOW,
  input wire logic CLOCK_FAULT,
  // reset pin and timer outputs
  output logic RESET_OUT_N,
  output logic LONG_LOW_EXPIRED,
  output logic CLOCK_WATCH_EN,
  output logic CLOCK_FAULT_SEEN,
  // configuration to the fault-input logic
  output logic [1:0] FAULT_INPUT_PAIRING,
  output logic PAIRED_FAULT_POLARITY,
  output logic FAULT_IN_A_POLARITY,
  output logic FAULT_IN_B_POLARITY,
  output logic PAIRED_FAULT_REACTION,
  output logic FAULT_IN_A_REACTION,
  output logic FAULT_IN_B_REACTION,
  output logic ERR_WATCH_POLARITY,
  output logic [1:0] ERR_WATCH_ACK_TIME,
  output logic ERR_WATCH_REACTION,
  output logic [1:0] FAULT_COUNT_LIMIT,
  output logic [1:0] FAULT_COUNT_REACTION
);
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  fsc_word_t fault_input_config_reg, fault_input_config_next;
  fsc_word_t failsafe_machine_config_reg, failsafe_machine_config_next;
  fsc_word_t rdata_reg, rdata_next;
  // clamped live counter, merged into machine reads
  logic [3:0] count_shown;

  // masked merge keeps reserved and read-only bits at their stored zero
  function automatic fsc_word_t fsc_merge(input fsc_word_t old_val, input fsc_word_t wr_val,
                                          input fsc_word_t mask);
    fsc_merge = (old_val & ~mask) | (wr_val & mask);
  endfunction

  // next register values on a write
  always_comb begin
    fault_input_config_next = fault_input_config_reg;
    failsafe_machine_config_next = failsafe_machine_config_reg;
    if (REG_WR && REG_SEL == `FSC_SEL_FAULT_INPUT) begin
      fault_input_config_next = fsc_merge(fault_input_config_reg, REG_WDATA,
                                          `FSC_FAULT_INPUT_MASK);
    end
    if (REG_WR && REG_SEL == `FSC_SEL_MACHINE) begin
      failsafe_machine_config_next = fsc_merge(failsafe_machine_config_reg, REG_WDATA,
                                               `FSC_MACHINE_MASK);
    end
  end

  // read data: counter merged live at read time, never latched at reset
  always_comb begin
    rdata_next = rdata_reg;
    if (REG_RD) begin
      if (REG_SEL == `FSC_SEL_FAULT_INPUT) begin
        rdata_next = fault_input_config_reg & `FSC_FAULT_INPUT_MASK;
      end else begin
        rdata_next = (failsafe_machine_config_reg & `FSC_MACHINE_MASK)
                   | {12'h000, count_shown};
      end
    end
  end

  // register process
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fault_input_config_reg <= `FSC_FAULT_INPUT_RST;
      failsafe_machine_config_reg <= `FSC_MACHINE_RST;
      rdata_reg <= '0;
    end else begin
      fault_input_config_reg <= fault_input_config_next;
      failsafe_machine_config_reg <= failsafe_machine_config_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  logic pulse_len_sel, short_high_resets_en, clock_watch_off, long_low_timer_off;
  assign pulse_len_sel = failsafe_machine_config_reg[`FSC_POS_PULSE_SEL];
  assign short_high_resets_en = failsafe_machine_config_reg[`FSC_POS_SHORT_HIGH];
  assign clock_watch_off = failsafe_machine_config_reg[`FSC_POS_CLOCK_OFF];
  assign long_low_timer_off = failsafe_machine_config_reg[`FSC_POS_LONG_OFF];
  // the counter never legally passes 12; clamp so a glitch cannot show more
  assign count_shown = (FAULT_ERROR_COUNT > `FSC_FAULT_COUNT_MAX) ? `FSC_FAULT_COUNT_MAX
                     : FAULT_ERROR_COUNT;

  assign REG_RDATA = rdata_reg;
  assign FAULT_INPUT_PAIRING = fault_input_config_reg[`FSC_POS_PAIRING +: 2];
  assign PAIRED_FAULT_POLARITY = fault_input_config_reg[`FSC_POS_PAIRED_POL];
  assign FAULT_IN_A_POLARITY = fault_input_config_reg[`FSC_POS_IN_A_POL];
  assign FAULT_IN_B_POLARITY = fault_input_config_reg[`FSC_POS_IN_B_POL];
  assign PAIRED_FAULT_REACTION = fault_input_config_reg[`FSC_POS_PAIRED_REACT];
  assign FAULT_IN_A_REACTION = fault_input_config_reg[`FSC_POS_IN_A_REACT];
  assign FAULT_IN_B_REACTION = fault_input_config_reg[`FSC_POS_IN_B_REACT];
  assign ERR_WATCH_POLARITY = fault_input_config_reg[`FSC_POS_ERR_POL];
  assign ERR_WATCH_ACK_TIME = fault_input_config_reg[`FSC_POS_ERR_ACK +: 2];
  assign ERR_WATCH_REACTION = fault_input_config_reg[`FSC_POS_ERR_REACT];
  assign FAULT_COUNT_LIMIT = failsafe_machine_config_reg[`FSC_POS_COUNT_LIMIT +: 2];
  assign FAULT_COUNT_REACTION = failsafe_machine_config_reg[`FSC_POS_COUNT_REACT +: 2];

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [2:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic short_prev_reg, short_prev_next, low_prev_reg, low_prev_next;
  logic clk_seen_reg, clk_seen_next, out_n_reg, out_n_next;
  logic short_rise, low_rise, reset_trigger, pulse_busy;
  fsc_count_t pulse_len;

  // first stage feeds only the second stage
  always_comb begin
    sync1_next = {CLOCK_FAULT, RESET_PIN_LOW, FAILSAFE_SHORT_HIGH};
    sync2_next = sync1_reg;
    short_prev_next = sync2_reg[0];
    low_prev_next = sync2_reg[1];
    clk_seen_next = sync2_reg[2] & ~clock_watch_off;
    out_n_next = ~pulse_busy;
  end

  assign short_rise = sync2_reg[0] & ~short_prev_reg;
  assign low_rise = sync2_reg[1] & ~low_prev_reg;
  // short to high only resets when enabled
  assign reset_trigger = RESET_REQ | (short_rise & short_high_resets_en);
  assign pulse_len = pulse_len_sel ? fsc_count_t'(PULSE_SHORT_CYC)
                   : fsc_count_t'(PULSE_LONG_CYC);

  // synchroniser and output registers
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      short_prev_reg <= 1'b0;
      low_prev_reg <= 1'b0;
      clk_seen_reg <= 1'b0;
      out_n_reg <= 1'b1;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      short_prev_reg <= short_prev_next;
      low_prev_reg <= low_prev_next;
      clk_seen_reg <= clk_seen_next;
      out_n_reg <= out_n_next;
    end
  end

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  // reset pulse; a new trigger during a pulse restarts it
  fsc_timer u_pulse (
    .clk(MCLK),
    .arst_n(ARST_N),
    .start(reset_trigger),
    .load_val(pulse_len),
    .clear(1'b0),
    .busy(pulse_busy),
    .done()
  );

  // long-low timer: cleared when the pin goes high or the timer is disabled
  fsc_timer u_long_low (
    .clk(MCLK),
    .arst_n(ARST_N),
    .start(low_rise),
    .load_val(fsc_count_t'(LONG_LOW_CYC)),
    .clear(long_low_timer_off | ~sync2_reg[1]),
    .busy(),
    .done(LONG_LOW_EXPIRED)
  );

  assign RESET_OUT_N = out_n_reg;
  assign CLOCK_WATCH_EN = ~clock_watch_off;
  assign CLOCK_FAULT_SEEN = clk_seen_reg;
endmodule

// >>> testbench/fsc_regs_asserts.sv
// checker for the fail-safe init configuration registers
`timescale 1ns/1ps
module fsc_regs_asserts
  import fsc_pkg::*;
#(
  parameter int PULSE_LONG_CYC = 40,
  parameter int PULSE_SHORT_CYC = 10,
  parameter int LONG_LOW_CYC = 100
)
(
  // clock, reset and register port
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic REG_SEL,
  input wire logic REG_WR,
  input wire fsc_word_t REG_WDATA,
  input wire logic REG_RD,
  input wire fsc_word_t REG_RDATA,
  // machine side, pins and outputs
  input wire logic RESET_REQ,
  input wire logic [3:0] FAULT_ERROR_COUNT,
  input wire logic FAILSAFE_SHORT_HIGH,
  input wire logic RESET_PIN_LOW,
  input wire logic CLOCK_FAULT,
  input wire logic RESET_OUT_N,
  input wire logic LONG_LOW_EXPIRED,
  input wire logic CLOCK_WATCH_EN,
  input wire logic CLOCK_FAULT_SEEN
);
  // ----------------------------------------------------------------
  // shadow state
  // ----------------------------------------------------------------
  // shadow of pulse select, short-high, clock off and long-timer off bits
  logic [3:0] ctl_reg, ctl_next;
  int low_reg, low_next, run_reg, run_next;
  always_comb begin
    ctl_next = ctl_reg;
    if (REG_WR && REG_SEL) begin
      ctl_next = {REG_WDATA[9], REG_WDATA[7], REG_WDATA[5:4]};
    end
    low_next = RESET_OUT_N ? 0 : low_reg + 1;
    run_next = RESET_PIN_LOW ? run_reg + 1 : 0;
  end
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctl_reg <= 4'h4;
      low_reg <= 0;
      run_reg <= 0;
    end else begin
      ctl_reg <= ctl_next;
      low_reg <= low_next;
      run_reg <= run_next;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  sequence req_s; RESET_REQ; endsequence
  sequence low_s; ##2 !RESET_OUT_N; endsequence
  a_pulse_starts: assert property (req_s |-> low_s)
    else $error("reset output not low two cycles after request");
  a_pulse_length: assert property ($rose(RESET_OUT_N) |->
    low_reg == (ctl_reg[3] ? PULSE_SHORT_CYC : PULSE_LONG_CYC)) else $error("reset pulse length wrong");
  a_short_high_on: assert property ($rose(FAILSAFE_SHORT_HIGH) && ctl_reg[2] |-> ##[2:6] !RESET_OUT_N)
    else $error("short to high did not assert reset");
  a_watch_follows: assert property (CLOCK_WATCH_EN == !ctl_reg[1])
    else $error("clock watch enable does not follow its bit");
  a_watch_gates: assert property (!CLOCK_WATCH_EN [*2] |-> !CLOCK_FAULT_SEEN)
    else $error("clock fault reported while watch off");
  a_watch_reports: assert property ((CLOCK_FAULT && CLOCK_WATCH_EN) [*4] |-> CLOCK_FAULT_SEEN)
    else $error("clock fault not reported");
  a_long_expiry: assert property (LONG_LOW_EXPIRED |-> !ctl_reg[0] &&
    run_reg >= LONG_LOW_CYC + 1 && run_reg <= LONG_LOW_CYC + 7) else $error("long low pulse misplaced");
  a_count_live: assert property (REG_RD && REG_SEL && $stable(FAULT_ERROR_COUNT) |-> ##2
    REG_RDATA[3:0] == (($past(FAULT_ERROR_COUNT, 2) > 4'hC) ? 4'hC : $past(FAULT_ERROR_COUNT, 2)))
    else $error("fault count readback wrong");
  a_reserved_zero: assert property (REG_RD |-> ##2
    (REG_RDATA & ~($past(REG_SEL, 2) ? 16'hDABF : 16'hDDDE)) == 16'h0000) else $error("reserved bit set");
endmodule

bind fsc_regs fsc_regs_asserts #(.PULSE_LONG_CYC(PULSE_LONG_CYC), .PULSE_SHORT_CYC(PULSE_SHORT_CYC),
  .LONG_LOW_CYC(LONG_LOW_CYC)) u_chk (.MCLK(MCLK), .ARST_N(ARST_N), .REG_SEL(REG_SEL), .REG_WR(REG_WR),
  .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RESET_REQ(RESET_REQ),
  .FAULT_ERROR_COUNT(FAULT_ERROR_COUNT), .FAILSAFE_SHORT_HIGH(FAILSAFE_SHORT_HIGH),
  .RESET_PIN_LOW(RESET_PIN_LOW), .CLOCK_FAULT(CLOCK_FAULT), .RESET_OUT_N(RESET_OUT_N),
  .LONG_LOW_EXPIRED(LONG_LOW_EXPIRED), .CLOCK_WATCH_EN(CLOCK_WATCH_EN), .CLOCK_FAULT_SEEN(CLOCK_FAULT_SEEN));

// >>> testbench/fsc_regs_tb.sv
// self-checking bench for the fail-safe init configuration registers
`timescale 1ns/1ps
module fsc_regs_tb;
  // ----------------------------------------------------------------
  // stimulus, clock and design
  // ----------------------------------------------------------------
  logic mclk = 1'b0, arst_n = 1'b0, sel = 1'b0, wr = 1'b0, rd = 1'b0, req = 1'b0;
  logic shorth = 1'b0, pinlow = 1'b0, cfault = 1'b0, rst_n, expired, wen, seen;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [3:0] cnt = 4'h0;
  // configuration outputs packed for one compare: pairing..error watch, then limit and reaction
  wire [15:0] cfg;
  int failures = 0, n_compared = 0, n;
  always #25 mclk = ~mclk;
  // small counts keep the pulses short; expectations use the same values
  fsc_regs #(.PULSE_LONG_CYC(40), .PULSE_SHORT_CYC(10), .LONG_LOW_CYC(100)) DUT (.MCLK(mclk), .ARST_N(arst_n),
    .REG_SEL(sel), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .RESET_REQ(req),
    .FAULT_ERROR_COUNT(cnt), .FAILSAFE_SHORT_HIGH(shorth), .RESET_PIN_LOW(pinlow), .CLOCK_FAULT(cfault),
    .RESET_OUT_N(rst_n), .LONG_LOW_EXPIRED(expired), .CLOCK_WATCH_EN(wen), .CLOCK_FAULT_SEEN(seen),
    .FAULT_INPUT_PAIRING(cfg[15:14]), .PAIRED_FAULT_POLARITY(cfg[13]), .FAULT_IN_A_POLARITY(cfg[12]),
    .FAULT_IN_B_POLARITY(cfg[11]), .PAIRED_FAULT_REACTION(cfg[10]), .FAULT_IN_A_REACTION(cfg[9]),
    .FAULT_IN_B_REACTION(cfg[8]), .ERR_WATCH_POLARITY(cfg[7]), .ERR_WATCH_ACK_TIME(cfg[6:5]),
    .ERR_WATCH_REACTION(cfg[4]), .FAULT_COUNT_LIMIT(cfg[3:2]), .FAULT_COUNT_REACTION(cfg[1:0]));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bus strobes last one cycle; called just after a falling edge
  task automatic wr_reg(input logic s, input logic [15:0] d);
    sel = s;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic s, input logic [15:0] e, input string nm);
    sel = s;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    repeat (2) @(negedge mclk);
    cmp16(nm, e, rdata);
  endtask
  // length of the next low pulse of the reset output, bounded both ways
  task automatic low_len(output int k);
    k = 0;
    for (int i = 0; i < 20 && rst_n === 1'b1; i++) begin
      @(negedge mclk);
    end
    while (rst_n === 1'b0 && k < 300) begin
      @(negedge mclk);
      k++;
    end
    if (k == 0 || k >= 300) begin
      failures++;
      summarize();
    end
  endtask
  initial begin
    repeat (20000) @(negedge mclk);
    failures++;
    summarize();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    rd_reg(1'b0, 16'h41C6, "inputs reset");
    rd_reg(1'b1, 16'h5080, "machine reset");
    cmp16("config reset", 16'h4736, cfg);
    wr_reg(1'b0, 16'hFFFF);
    rd_reg(1'b0, 16'hDDDE, "inputs ones");
    wr_reg(1'b1, 16'hFFFF);
    rd_reg(1'b1, 16'hDAB0, "machine ones");
    cmp16("config ones", 16'hFFFF, cfg);
    cfault = 1'b1;
    repeat (6) @(negedge mclk);
    cmp16("watch off", 16'h0000, {14'h0000, wen, seen});
    wr_reg(1'b1, 16'h0080);
    repeat (6) @(negedge mclk);
    cmp16("watch on", 16'h0003, {14'h0000, wen, seen});
    cmp16("config machine", 16'hFFF0, cfg);
    cfault = 1'b0;
    for (int i = 0; i < 16; i++) begin
      cnt = 4'(i);
      @(negedge mclk);
      rd_reg(1'b1, 16'h0080 | 16'(i > 12 ? 12 : i), "fault count");
    end
    cnt = 4'h0;
    for (int s = 0; s < 2; s++) begin
      wr_reg(1'b1, (s == 1) ? 16'h0280 : 16'h0080);
      req = 1'b1;
      @(negedge mclk);
      req = 1'b0;
      low_len(n);
      cmp16("pulse length", (s == 1) ? 16'h000A : 16'h0028, 16'(n));
    end
    wr_reg(1'b1, 16'h0000);
    shorth = 1'b1;
    repeat (10) @(negedge mclk);
    cmp16("short high ignored", 16'h0001, {15'h0000, rst_n});
    shorth = 1'b0;
    repeat (4) @(negedge mclk);
    wr_reg(1'b1, 16'h0080);
    shorth = 1'b1;
    low_len(n);
    cmp16("short high pulse", 16'h0028, 16'(n));
    shorth = 1'b0;
    pinlow = 1'b1;
    n = 0;
    while (expired !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    cmp16("long low fired", 16'h0001, {15'h0000, expired && n >= 100});
    if (expired !== 1'b1) begin
      summarize();
    end
    pinlow = 1'b0;
    repeat (4) @(negedge mclk);
    wr_reg(1'b1, 16'h0010);
    pinlow = 1'b1;
    n = 0;
    repeat (150) begin
      @(negedge mclk);
      n += int'(expired === 1'b1);
    end
    cmp16("long low off", 16'h0000, 16'(n));
    pinlow = 1'b0;
    arst_n = 1'b0;
    @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    rd_reg(1'b1, 16'h5080, "machine rereset");
    summarize();
  end
endmodule
